// ---- logic/hsims_top.v ----
// Purpose: High-speed interrupt microframe scheduler with Wishbone register file
// Assumes: Link-side inputs synchronous to clk_i; one transaction outstanding
// Notes:   Counts live in hsims_cnt_mem and are read with one extra wait state
`timescale 1ns/10ps
`default_nettype none
`include "hsims_regs.vh"

module hsims_top (
  input  wire                        clk_i,         // Controller clock, 25 MHz
  input  wire                        arst_n_i,      // Async reset, active low
  // Wishbone classic slave
  input  wire                        wb_cyc_i,      // Bus cycle
  input  wire                        wb_stb_i,      // Strobe
  input  wire                        wb_we_i,       // Write enable
  input  wire [`HSIMS_ADR_W-1:0]     wb_adr_i,      // Byte address
  input  wire [3:0]                  wb_sel_i,      // Byte enables
  input  wire [31:0]                 wb_dat_i,      // Write data
  output wire [31:0]                 wb_dat_o,      // Read data
  output wire                        wb_ack_o,      // Acknowledge
  output wire                        irq_o,         // Level interrupt, active high
  // Link side
  input  wire                        sof_i,         // Microframe start pulse
  input  wire [`HSIMS_UF_W-1:0]      uframe_i,      // Current microframe number
  input  wire [`HSIMS_FRM_W-1:0]     bus_frame_i,   // Current bus frame number bits
  output wire                        xact_req_o,    // Transaction request level
  output wire [`HSIMS_UF_W-1:0]      xact_uframe_o, // Microframe of the request
  output wire                        xact_in_o,     // 1 = IN token, 0 = OUT token
  input  wire                        xact_done_i,   // Transaction finished pulse
  input  wire                        xact_err_i,    // Transaction error seen
  input  wire                        xact_babble_i, // Babble seen
  input  wire                        xact_undr_i,   // Underrun seen
  input  wire [`HSIMS_CNT_W-1:0]     xact_bytes_i   // Bytes received
);

  localparam [`HSIMS_ST_W-1:0] ST_IDLE = `HSIMS_ST_IDLE;
  localparam [`HSIMS_ST_W-1:0] ST_BUSY = `HSIMS_ST_BUSY;

  // Register state
  reg  [`HSIMS_FRM_W-1:0]              frame_ff;
  reg  [`HSIMS_NUM_UF-1:0]             mask_ff;
  reg  [`HSIMS_NUM_UF*`HSIMS_RES_W-1:0] res_ff;
  reg  [1:0]                           ctrl_ff;
  reg  [`HSIMS_IRQ_W-1:0]              istat_ff;
  reg  [`HSIMS_IRQ_W-1:0]              imask_ff;
  reg  [31:0]                          dat_ff;
  reg                                  ack_ff;
  reg                                  wait_ff;

  // Scheduler state
  reg  [`HSIMS_ST_W-1:0]               st_ff;
  reg  [`HSIMS_ST_W-1:0]               nxt_st;
  reg  [`HSIMS_UF_W-1:0]               uf_ff;
  reg  [`HSIMS_UF_W-1:0]               nxt_uf;
  reg                                  in_ff;
  reg                                  nxt_in;

  wire                                 req_vld;
  wire                                 wr_en;
  wire                                 cnt_hit;
  wire                                 start;
  wire                                 finish;
  wire [`HSIMS_UF_W-1:0]               cnt_idx;
  wire [`HSIMS_CNT_W-1:0]              cnt_rdata;
  wire [`HSIMS_RES_W-1:0]              res_val;
  wire [`HSIMS_NUM_UF-1:0]             mask_set;
  wire [`HSIMS_NUM_UF-1:0]             mask_clr;
  wire [`HSIMS_IRQ_W-1:0]              ev;
  wire [`HSIMS_IRQ_W-1:0]              istat_clr;
  reg  [31:0]                          rd_mux;

  // ---------------------------------------------------------------- Bus
  assign req_vld = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master samples ack
  assign wr_en   = req_vld & wb_we_i & ack_ff;
  assign cnt_hit = (wb_adr_i[`HSIMS_CNT_SEL_MSB:`HSIMS_CNT_SEL_LSB] == `HSIMS_CNT_SEL_VAL);
  assign cnt_idx = wb_adr_i[4:2];

  always @* begin
    rd_mux = 32'h0000_0000;
    if (cnt_hit) begin
      rd_mux = {20'h0_0000, cnt_rdata};
    end else begin
      case (wb_adr_i)
        `HSIMS_OFF_WORD_TWO:
          rd_mux = {24'h00_0000, frame_ff, 3'h0};
        `HSIMS_OFF_WORD_FOUR:
          rd_mux = {res_ff, mask_ff};
        `HSIMS_OFF_CTRL:
          rd_mux = {30'h0000_0000, ctrl_ff};
        `HSIMS_OFF_INT_STAT:
          rd_mux = {30'h0000_0000, istat_ff};
        `HSIMS_OFF_INT_MASK:
          rd_mux = {30'h0000_0000, imask_ff};
        default:
          rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Count reads wait one edge for the registered memory output
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_ff  <= 1'b0;
      wait_ff <= 1'b0;
      dat_ff  <= 32'h0000_0000;
    end else begin
      if (ack_ff) begin
        ack_ff  <= 1'b0;
        wait_ff <= 1'b0;
      end else if (wait_ff) begin
        ack_ff  <= 1'b1;
        wait_ff <= 1'b0;
        dat_ff  <= {20'h0_0000, cnt_rdata};
      end else if (req_vld) begin
        if (cnt_hit && !wb_we_i) begin
          wait_ff <= 1'b1;
        end else begin
          ack_ff <= 1'b1;
          dat_ff <= rd_mux;
        end
      end
    end
  end

  assign wb_ack_o = ack_ff & req_vld;
  assign wb_dat_o = dat_ff;

  // ---------------------------------------------------------- Software regs
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frame_ff <= 5'h00;
      ctrl_ff  <= `HSIMS_RST_CTRL;
      imask_ff <= `HSIMS_RST_IRQ;
    end else if (wr_en) begin
      case (wb_adr_i)
        `HSIMS_OFF_WORD_TWO: begin
          if (wb_sel_i[0]) begin
            frame_ff <= wb_dat_i[`HSIMS_FRM_MSB:`HSIMS_FRM_LSB];
          end
        end
        `HSIMS_OFF_CTRL: begin
          if (wb_sel_i[0]) begin
            ctrl_ff <= wb_dat_i[1:0];
          end
        end
        `HSIMS_OFF_INT_MASK: begin
          if (wb_sel_i[0]) begin
            imask_ff <= wb_dat_i[`HSIMS_IRQ_W-1:0];
          end
        end
        default: begin
          ctrl_ff <= ctrl_ff;
        end
      endcase
    end
  end

  // Software can only raise mask bits; writing zero has no effect
  assign mask_set = (wr_en && (wb_adr_i == `HSIMS_OFF_WORD_FOUR) && wb_sel_i[0]) ?
                    wb_dat_i[`HSIMS_MASK_MSB:`HSIMS_MASK_LSB] : 8'h00;

  // ------------------------------------------------------------- Scheduler
  // Mask is sampled only when the descriptor frame matches the bus frame
  assign start  = st_ff[0] & sof_i & ctrl_ff[`HSIMS_CTRL_EN] &
                  (frame_ff == bus_frame_i) & mask_ff[uframe_i];
  assign finish = st_ff[1] & xact_done_i;

  always @* begin
    nxt_st = st_ff;
    nxt_uf = uf_ff;
    nxt_in = in_ff;
    case (st_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_st = ST_BUSY;
          nxt_uf = uframe_i;
          nxt_in = ctrl_ff[`HSIMS_CTRL_TOKEN_IN];
        end
      end
      ST_BUSY: begin
        if (xact_done_i) begin
          nxt_st = ST_IDLE;
        end
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff <= ST_IDLE;
      uf_ff <= 3'h0;
      in_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      uf_ff <= nxt_uf;
      in_ff <= nxt_in;
    end
  end

  assign xact_req_o    = st_ff[1];
  assign xact_uframe_o = uf_ff;
  assign xact_in_o     = in_ff;

  // Result code: babble and underrun bits qualified by token direction, error bit is not
  assign res_val[`HSIMS_RES_ERR]      = xact_err_i;
  assign res_val[`HSIMS_RES_BABBLE]   = xact_babble_i & in_ff;
  assign res_val[`HSIMS_RES_UNDERRUN] = xact_undr_i & ~in_ff;

  genvar gi;
  generate
    for (gi = 0; gi < `HSIMS_NUM_UF; gi = gi + 1) begin : g_uf
      localparam [`HSIMS_UF_W-1:0] UF_IDX = gi;
      assign mask_clr[gi] = finish & (uf_ff == UF_IDX);

      // A software set in the clearing cycle wins
      always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          mask_ff[gi] <= 1'b0;
        end else if (mask_set[gi]) begin
          mask_ff[gi] <= 1'b1;
        end else if (mask_clr[gi]) begin
          mask_ff[gi] <= 1'b0;
        end
      end

      // Only the processed microframe's field is touched
      always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          res_ff[gi*`HSIMS_RES_W +: `HSIMS_RES_W] <= 3'h0;
        end else if (mask_clr[gi]) begin
          res_ff[gi*`HSIMS_RES_W +: `HSIMS_RES_W] <= res_val;
        end
      end
    end
  endgenerate

  hsims_cnt_mem u_cnt_mem (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .we_i     (finish),
    .waddr_i  (uf_ff),
    .wdata_i  (xact_bytes_i),
    .raddr_i  (cnt_idx),
    .rdata_o  (cnt_rdata)
  );

  // -------------------------------------------------------------- Interrupt
  assign ev[`HSIMS_IRQ_DONE] = finish;
  assign ev[`HSIMS_IRQ_FAIL] = finish & (|res_val);
  assign istat_clr = (wr_en && (wb_adr_i == `HSIMS_OFF_INT_STAT) && wb_sel_i[0]) ?
                     wb_dat_i[`HSIMS_IRQ_W-1:0] : 2'h0;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      istat_ff <= `HSIMS_RST_IRQ;
    end else begin
      istat_ff <= (istat_ff & ~istat_clr) | ev;
    end
  end

  assign irq_o = |(istat_ff & imask_ff);

endmodule // hsims_top

`default_nettype wire

// ---- logic/hsims_regs.vh ----
// Purpose: Register offsets, fields, reset values and state codes of the scheduler
// Assumes: Byte addresses on a 32-bit classic Wishbone bus
// Notes:   Included by bare name
`ifndef HSIMS_REGS_VH
`define HSIMS_REGS_VH

// Register byte offsets
`define HSIMS_ADR_W          8
`define HSIMS_OFF_WORD_TWO   8'h00
`define HSIMS_OFF_WORD_FOUR  8'h04
`define HSIMS_OFF_CTRL       8'h08
`define HSIMS_OFF_INT_STAT   8'h0C
`define HSIMS_OFF_INT_MASK   8'h10
`define HSIMS_OFF_CNT_BASE   8'h20
`define HSIMS_CNT_SEL_MSB    7
`define HSIMS_CNT_SEL_LSB    5
`define HSIMS_CNT_SEL_VAL    3'h1

// Descriptor word two: frame number field
`define HSIMS_FRM_MSB        7
`define HSIMS_FRM_LSB        3
`define HSIMS_FRM_W          5

// Descriptor word four: mask and result fields
`define HSIMS_MASK_MSB       7
`define HSIMS_MASK_LSB       0
`define HSIMS_RES_LSB        8
`define HSIMS_RES_W          3
`define HSIMS_NUM_UF         8
`define HSIMS_UF_W           3
`define HSIMS_RES_ERR        0
`define HSIMS_RES_BABBLE     1
`define HSIMS_RES_UNDERRUN   2

// Byte count field
`define HSIMS_CNT_W          12

// Control register bits
`define HSIMS_CTRL_EN        0
`define HSIMS_CTRL_TOKEN_IN  1

// Interrupt status / mask bits
`define HSIMS_IRQ_W          2
`define HSIMS_IRQ_DONE       0
`define HSIMS_IRQ_FAIL       1

// Reset values
`define HSIMS_RST_WORD_TWO   32'h0000_0000
`define HSIMS_RST_MASK       8'h00
`define HSIMS_RST_RES        24'h00_0000
`define HSIMS_RST_CTRL       2'h0
`define HSIMS_RST_IRQ        2'h0

// One-hot scheduler states
`define HSIMS_ST_W           2
`define HSIMS_ST_IDLE        2'h1
`define HSIMS_ST_BUSY        2'h2

`endif

// ---- logic/hsims_cnt_mem.v ----
// Purpose: Eight-entry store of per-microframe received byte counts
// Assumes: One write port, one read port, same clock
// Notes:   Read data come out of a register one edge after the address
`timescale 1ns/10ps
`default_nettype none
`include "hsims_regs.vh"

module hsims_cnt_mem (
  input  wire                        clk_i,    // Controller clock
  input  wire                        arst_n_i, // Async reset, active low
  input  wire                        we_i,     // Write strobe
  input  wire [`HSIMS_UF_W-1:0]      waddr_i,  // Write index (microframe)
  input  wire [`HSIMS_CNT_W-1:0]     wdata_i,  // Byte count to store
  input  wire [`HSIMS_UF_W-1:0]      raddr_i,  // Read index
  output reg  [`HSIMS_CNT_W-1:0]     rdata_o   // Registered read data
);

  reg [`HSIMS_CNT_W-1:0] mem_ff [0:`HSIMS_NUM_UF-1];

  genvar gi;
  generate
    for (gi = 0; gi < `HSIMS_NUM_UF; gi = gi + 1) begin : g_ent
      localparam [`HSIMS_UF_W-1:0] ENT_IDX = gi;
      always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          mem_ff[gi] <= 12'h000;
        end else if (we_i && (waddr_i == ENT_IDX)) begin
          mem_ff[gi] <= wdata_i;
        end
      end
    end
  endgenerate

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 12'h000;
    end else begin
      rdata_o <= mem_ff[raddr_i];
    end
  end

endmodule // hsims_cnt_mem

`default_nettype wire

// ---- verif/hsims_ep_model.sv ----
// Purpose: Behavioural interrupt endpoint answering scheduler requests
// Assumes: One request at a time, held until done is sampled
// Notes:   Status lines toggle while no answer is given
`timescale 1ns/10ps
`default_nettype none
module hsims_ep_model (
  input  wire logic        clk_i,    // Controller clock
  input  wire logic        arst_n_i, // Async reset, active low
  input  wire logic        req_i,    // Transaction request
  input  wire logic [2:0]  uf_i,     // Microframe of request
  input  wire logic        slow_i,   // Answer late
  input  wire logic [2:0]  st_i,     // Status to report
  output var  logic        done_o,   // Finish pulse
  output var  logic [2:0]  st_o,     // Reported status
  output var  logic [11:0] bytes_o   // Received byte count
);
  logic [3:0] cnt_ff;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff  <= 4'h0;
      done_o  <= 1'b0;
      st_o    <= 3'h0;
      bytes_o <= 12'h000;
    end else if (req_i && !done_o && cnt_ff == (slow_i ? 4'h6 : 4'h1)) begin
      done_o  <= 1'b1;
      st_o    <= st_i;
      bytes_o <= {uf_i, 9'h0A5};
    end else begin
      // Lines carry no meaning outside the pulse, so keep them moving
      cnt_ff  <= (req_i && !done_o) ? cnt_ff + 4'h1 : 4'h0;
      done_o  <= 1'b0;
      st_o    <= ~st_o;
      bytes_o <= ~bytes_o;
    end
  end
endmodule // hsims_ep_model
`default_nettype wire

// ---- verif/hsims_chk.sv ----
// Purpose: Port-level assertions for the microframe scheduler
// Assumes: Single clock domain
// Notes:   Attached by bind below
`timescale 1ns/10ps
`default_nettype none
`include "hsims_regs.vh"
module hsims_chk (
  input  wire logic                   clk_i,         // Clock
  input  wire logic                   arst_n_i,      // Reset, active low
  input  wire logic                   wb_cyc_i,      // Bus cycle
  input  wire logic                   wb_stb_i,      // Strobe
  input  wire logic                   wb_we_i,       // Write enable
  input  wire logic                   wb_ack_o,      // Acknowledge
  input  wire logic                   irq_o,         // Interrupt
  input  wire logic                   sof_i,         // Microframe start
  input  wire logic [`HSIMS_UF_W-1:0] uframe_i,      // Microframe number
  input  wire logic                   xact_req_o,    // Request
  input  wire logic [`HSIMS_UF_W-1:0] xact_uframe_o, // Request microframe
  input  wire logic                   xact_done_i    // Done pulse
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  chk_req_needs_sof:
    assert property ($rose(xact_req_o) |-> $past(sof_i)) else $error("request without start");
  chk_req_uframe:
    assert property ($rose(xact_req_o) |-> xact_uframe_o == $past(uframe_i))
      else $error("request microframe wrong");
  chk_idle_stays:
    assert property (!xact_req_o && !sof_i |=> !xact_req_o) else $error("request from idle");
  chk_req_ends:
    assert property (xact_req_o && xact_done_i |=> !xact_req_o) else $error("request not ended");
  chk_req_holds:
    assert property (xact_req_o && !xact_done_i |=> xact_req_o && $stable(xact_uframe_o))
      else $error("request dropped early");
  chk_irq_cause:
    assert property ($rose(irq_o) |-> $past(xact_done_i && xact_req_o) || $past(wb_cyc_i && wb_we_i))
      else $error("interrupt without event");
  chk_ack_bound:
    assert property ($rose(wb_cyc_i && wb_stb_i) |-> ##[1:2] wb_ack_o) else $error("ack late");
  chk_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_ack_qual:
    assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i) else $error("ack without cycle");
endmodule // hsims_chk
bind hsims_top hsims_chk u_chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .sof_i(sof_i),
  .uframe_i(uframe_i), .xact_req_o(xact_req_o), .xact_uframe_o(xact_uframe_o),
  .xact_done_i(xact_done_i));
`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench for the microframe scheduler
// Assumes: Endpoint model answers each request
// Notes:   Expected word four and counts tracked in exp_w4 and exp_cnt
`timescale 1ns/10ps
`default_nettype none
`include "hsims_regs.vh"
module testbench;
  logic        clk_i, arst_n_i, cyc, stb, we, sof, slow, tok, ack, irq, req, xin, done;
  logic [7:0]  adr;
  logic [31:0] dat_w, dat_r, q, exp_w4;
  logic [2:0]  uf, st, pst, xuf;
  logic [4:0]  bfrm;
  logic [11:0] bytes;
  logic [11:0] exp_cnt [0:7];
  integer      bad_count, comparisons, i;
  hsims_top DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .irq_o(irq), .sof_i(sof), .uframe_i(uf), .bus_frame_i(bfrm),
    .xact_req_o(req), .xact_uframe_o(xuf), .xact_in_o(xin), .xact_done_i(done),
    .xact_err_i(pst[0]), .xact_babble_i(pst[1]), .xact_undr_i(pst[2]), .xact_bytes_i(bytes));
  hsims_ep_model u_ep (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req), .uf_i(xuf),
    .slow_i(slow), .st_i(st), .done_o(done), .st_o(pst), .bytes_o(bytes));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task complete_run;
    begin
      $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task check(input string name, input logic [31:0] seen, input logic [31:0] expv);
    begin
      comparisons = comparisons + 1;
      if (seen !== expv) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %s expected %h seen %h", name, expv, seen);
      end
    end
  endtask
  task hang(input integer n);
    if (n >= 20) begin
      bad_count = bad_count + 1;
      $display("MISMATCH wait expected answer seen timeout");
      complete_run();
    end
  endtask
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    integer n;
    begin
      n = 0;
      adr <= a;
      we <= w;
      dat_w <= d;
      cyc <= 1'b1;
      stb <= 1'b1;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 20) begin
        @(posedge clk_i);
        n = n + 1;
      end
      hang(n);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task run_uf(input logic [2:0] u, input logic expq);
    integer n;
    begin
      n = 0;
      sof <= 1'b1;
      uf <= u;
      st <= u;
      @(posedge clk_i);
      sof <= 1'b0;
      while (req !== 1'b1 && n < 4) begin
        @(posedge clk_i);
        n = n + 1;
      end
      check("request", req, expq);
      if (expq) begin
        check("request uframe", xuf, u);
        check("token", xin, tok);
        n = 0;
        while (req === 1'b1 && n < 20) begin
          @(posedge clk_i);
          n = n + 1;
        end
        hang(n);
        exp_w4[8 + 3 * u +: 3] = tok ? {1'b0, u[1], u[0]} : {u[2], 1'b0, u[0]};
        exp_w4[u] = 1'b0;
        exp_cnt[u] = {u, 9'h0A5};
      end
    end
  endtask
  task verify;
    begin
      wb(`HSIMS_OFF_WORD_FOUR, 1'b0, 32'h0000_0000);
      check("word four", q, exp_w4);
      for (i = 0; i < 8; i = i + 1) begin
        wb({3'h1, i[2:0], 2'h0}, 1'b0, 32'h0000_0000);
        check("count", q, {20'h0_0000, exp_cnt[i]});
      end
    end
  endtask
  initial begin
    {arst_n_i, cyc, stb, we, sof, slow, adr, dat_w, uf, st, bfrm} = '0;
    tok = 1'b1;
    exp_w4 = 32'h0000_0000;
    bad_count = 0;
    comparisons = 0;
    for (i = 0; i < 8; i = i + 1) exp_cnt[i] = 12'h000;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    verify();
    wb(8'h40, 1'b0, 32'h0000_0000);
    check("unmapped", q, 32'h0000_0000);
    wb(`HSIMS_OFF_WORD_TWO, 1'b1, 32'h0000_0028);
    bfrm <= 5'h05;
    wb(`HSIMS_OFF_CTRL, 1'b1, 32'h0000_0003);
    wb(`HSIMS_OFF_INT_MASK, 1'b1, 32'h0000_0003);
    wb(`HSIMS_OFF_WORD_FOUR, 1'b1, 32'h0000_00FF);
    exp_w4[7:0] = 8'hFF;
    for (i = 0; i < 8; i = i + 1) run_uf(i[2:0], 1'b1);
    verify();
    check("irq", irq, 1'b1);
    wb(`HSIMS_OFF_INT_STAT, 1'b0, 32'h0000_0000);
    check("int status", q, 32'h0000_0003);
    wb(`HSIMS_OFF_INT_STAT, 1'b1, 32'h0000_0003);
    check("irq cleared", irq, 1'b0);
    tok = 1'b0;
    slow <= 1'b1;
    wb(`HSIMS_OFF_CTRL, 1'b1, 32'h0000_0001);
    wb(`HSIMS_OFF_WORD_FOUR, 1'b1, 32'h0000_0055);
    exp_w4[7:0] = 8'h55;
    for (i = 0; i < 8; i = i + 1) run_uf(i[2:0], ~i[0]);
    verify();
    slow <= 1'b0;
    bfrm <= 5'h06;
    wb(`HSIMS_OFF_WORD_FOUR, 1'b1, 32'h0000_0011);
    exp_w4[7:0] = 8'h11;
    run_uf(3'h0, 1'b0);
    wb(`HSIMS_OFF_WORD_FOUR, 1'b1, 32'h0000_0000);
    verify();
    bfrm <= 5'h05;
    for (i = 0; i < 8; i = i + 1) run_uf(i[2:0], i[1:0] == 2'h0);
    verify();
    complete_run();
  end
endmodule // testbench
`default_nettype wire
